// [verilog/dsp_exec_unit.v]
// Control, repeat, interlock and integer unit behind APB
// How it works
// (RQ1) Interrupt return with true condition pops stack into PC, sets interrupt enable.
// (RQ2) Subroutine return with true condition pops stack into PC, else continues.
// (RQ3) Plain rotates move the destination one bit, end bit wraps around.
// (RQ4) Carry rotates put carry into the ring; outgoing bit lands in carry.
// (RQ5) Block repeat loads end address, sets repeat mode, start gets next PC.
// (RQ6) Single repeat loads counter, sets repeat mode, start and end get next PC.
// (RQ7) Interlock signal raises request, waits for acknowledge, then drops request.
// (RQ8) Interlocked stores write source to memory address and mark interlock end.
// (RQ9) Borrow subtract is minuend minus source minus carry.
// (RQ10) Conditional subtract shifts difference in with one, or destination with zero.
// (RQ11) Reverse subtracts compute source minus destination, with carry for borrow form.
// (RQ12) True trap with vector up to 0x1B pushes next PC at pre-incremented pointer, loads vector, clears enable.
// (RQ13) Bit tests AND the operands for flags only, no register write.
// (RQ14) Software interrupt starts the emulator interrupt sequence.
// (RQ15) PC drives program address bus; instruction register loads every cycle.
// (RQ16) Two data address buses and data bus give two operands each cycle.
// (RQ17) Two register operand buses each carry one register value every cycle.
// (RQ18) DMA address and data buses run alongside program and data buses.
// (RQ19) Rotates, subtracts and tests use 32 bits and update status flags, except conditional subtract, which leaves them.
// (RQ20) Returns post-decrement the stack pointer after reading the top of stack.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "dsp_exec_consts.vh"
module dsp_exec_unit #(
    parameter STACK_ADDR_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [23:0] program_addr_bus,
    input wire [31:0] program_data_bus,
    output reg [31:0] instruction_reg,
    output reg [23:0] data_addr_bus_a,
    output reg [23:0] data_addr_bus_b,
    input wire [31:0] data_rd_a,
    input wire [31:0] data_rd_b,
    output reg [31:0] data_data_bus,
    output reg data_wr,
    output reg [31:0] cpu_operand_bus_a,
    output reg [31:0] cpu_operand_bus_b,
    output reg [31:0] reg_operand_bus_a,
    output reg [31:0] reg_operand_bus_b,
    input wire [23:0] dma_addr_in,
    input wire [31:0] dma_data_in,
    output reg [23:0] dma_addr_bus,
    output reg [31:0] dma_data_bus,
    output reg interlock_req,
    input wire interlock_ack,
    output reg interlock_end,
    output reg emu_irq
);
    localparam S_IDLE = 1'b0;
    localparam S_WAIT_ACK = 1'b1;

    reg state;
    reg [31:0] dst;
    reg [31:0] src1;
    reg [31:0] src2;
    reg [31:0] status_reg;
    reg [31:0] stack_pointer;
    reg [23:0] pc;
    reg [23:0] repeat_start_reg;
    reg [23:0] repeat_end_reg;
    reg [31:0] repeat_counter_reg;
    reg emu_pending;
    reg ack_meta;
    reg ack_sync;

    wire [7:0] ofs;
    wire mapped;
    wire wr_access;
    wire cmd_go;
    wire [4:0] op;
    wire cond_true;
    wire [4:0] trap_vec;
    wire [23:0] next_pc;
    wire [31:0] sp_inc;
    wire [31:0] sp_dec;
    wire [31:0] tos;
    wire push_en;
    wire [31:0] alu_result;
    wire alu_carry;
    wire alu_ovf;
    wire alu_write;
    wire alu_flags;
    wire alu_carry_upd;
    reg [31:0] read_mux;

    assign ofs = paddr[7:0];
    assign mapped = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0)
        && (ofs <= `OFS_TOS);
    // Read data is latched in setup, answered in access
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wr_access = psel & penable & pwrite & mapped;
    // A command written while an interlock wait is pending is dropped
    assign cmd_go = wr_access && (ofs == `OFS_COMMAND) && (state == S_IDLE);
    assign op = pwdata[`CMD_OP_MSB:0];
    assign cond_true = pwdata[`CMD_COND_BIT];
    assign trap_vec = pwdata[`CMD_VEC_MSB:`CMD_VEC_LSB];
    assign next_pc = pc + 24'h1;
    assign sp_inc = stack_pointer + 32'h1;
    assign sp_dec = stack_pointer - 32'h1;
    // (RQ12) push next PC at pre-incremented pointer
    assign push_en = cmd_go && (op == `OP_TRAP) && cond_true
        && (trap_vec <= `TRAP_VEC_LAST);
    // (RQ15) PC drives program address bus
    assign program_addr_bus = pc;

    stack_ram #(
        .ADDR_W(STACK_ADDR_W)
    ) u_stack (
        .pclk(pclk),
        .wr_en(push_en),
        .wr_addr(sp_inc[STACK_ADDR_W-1:0]),
        .wr_data({8'h00, next_pc}),
        .rd_addr(stack_pointer[STACK_ADDR_W-1:0]),
        .rd_data(tos)
    );

    int_alu u_alu (
        .op(op),
        .dst(dst),
        .src1(src1),
        .src2(src2),
        .carry_in(status_reg[`ST_CARRY]),
        .result(alu_result),
        .carry_out(alu_carry),
        .overflow(alu_ovf),
        .write_dst(alu_write),
        .flags_upd(alu_flags),
        .carry_upd(alu_carry_upd)
    );

    always @* begin
        read_mux = 32'h0;
        case (ofs)
            `OFS_DST: read_mux = dst;
            `OFS_SRC1: read_mux = src1;
            `OFS_SRC2: read_mux = src2;
            `OFS_STATUS: read_mux = status_reg;
            `OFS_STACK_PTR: read_mux = stack_pointer;
            `OFS_PC: read_mux = {8'h00, pc};
            `OFS_RPT_START: read_mux = {8'h00, repeat_start_reg};
            `OFS_RPT_END: read_mux = {8'h00, repeat_end_reg};
            `OFS_RPT_COUNT: read_mux = repeat_counter_reg;
            `OFS_INFO: begin
                read_mux[`INFO_BUSY] = (state == S_WAIT_ACK);
                read_mux[`INFO_EMU] = emu_pending;
                read_mux[`INFO_LOCK] = interlock_req;
            end
            `OFS_TOS: read_mux = tos;
            default: read_mux = 32'h0;
        endcase
    end

    // Acknowledge is asynchronous: two flops first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= interlock_ack;
            ack_sync <= ack_meta;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= mapped ? read_mux : 32'h0;
        end
    end

    // Core buses refresh every machine cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instruction_reg <= 32'h0;
            data_addr_bus_b <= 24'h0;
            cpu_operand_bus_a <= 32'h0;
            cpu_operand_bus_b <= 32'h0;
            reg_operand_bus_a <= 32'h0;
            reg_operand_bus_b <= 32'h0;
            dma_addr_bus <= 24'h0;
            dma_data_bus <= 32'h0;
        end else begin
            // (RQ15) one instruction word per cycle
            instruction_reg <= program_data_bus;
            // (RQ16) second data address and both operands
            data_addr_bus_b <= src2[23:0];
            cpu_operand_bus_a <= data_rd_a;
            cpu_operand_bus_b <= data_rd_b;
            // (RQ17) register operand buses
            reg_operand_bus_a <= dst;
            reg_operand_bus_b <= src1;
            // (RQ18) independent DMA path
            dma_addr_bus <= dma_addr_in;
            dma_data_bus <= dma_data_in;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            dst <= 32'h0;
            src1 <= 32'h0;
            src2 <= 32'h0;
            status_reg <= `RST_STATUS;
            stack_pointer <= `RST_SP;
            pc <= `RST_PC;
            repeat_start_reg <= 24'h0;
            repeat_end_reg <= 24'h0;
            repeat_counter_reg <= 32'h0;
            emu_pending <= 1'b0;
            interlock_req <= 1'b0;
            interlock_end <= 1'b0;
            emu_irq <= 1'b0;
            data_wr <= 1'b0;
            data_addr_bus_a <= 24'h0;
            data_data_bus <= 32'h0;
        end else begin
            interlock_end <= 1'b0;
            emu_irq <= 1'b0;
            data_wr <= 1'b0;
            data_addr_bus_a <= src1[23:0];
            // (RQ7) drop request once acknowledge arrives
            if (state == S_WAIT_ACK && ack_sync) begin
                interlock_req <= 1'b0;
                state <= S_IDLE;
            end
            if (wr_access) begin
                case (ofs)
                    `OFS_DST: dst <= pwdata;
                    `OFS_SRC1: src1 <= pwdata;
                    `OFS_SRC2: src2 <= pwdata;
                    `OFS_STATUS: status_reg <= pwdata;
                    `OFS_STACK_PTR: stack_pointer <= pwdata;
                    `OFS_PC: pc <= pwdata[23:0];
                    `OFS_RPT_START: repeat_start_reg <= pwdata[23:0];
                    `OFS_RPT_END: repeat_end_reg <= pwdata[23:0];
                    `OFS_RPT_COUNT: repeat_counter_reg <= pwdata;
                    `OFS_INFO: begin
                        if (pwdata[`INFO_EMU]) begin
                            emu_pending <= 1'b0;
                        end
                    end
                    default: dst <= dst;
                endcase
            end
            if (cmd_go) begin
                case (op)
                    `OP_RETI: begin
                        // (RQ1) pop into PC and enable interrupts
                        if (cond_true) begin
                            pc <= tos[23:0];
                            status_reg[`ST_GIE] <= 1'b1;
                            // (RQ20) post-decrement after read
                            stack_pointer <= sp_dec;
                        end
                    end
                    `OP_RETS: begin
                        // (RQ2) pop into PC
                        if (cond_true) begin
                            pc <= tos[23:0];
                            // (RQ20) post-decrement after read
                            stack_pointer <= sp_dec;
                        end
                    end
                    `OP_BLOCK_REPEAT_OP: begin
                        // (RQ5) block repeat setup
                        repeat_end_reg <= src1[23:0];
                        status_reg[`ST_RPT_MODE] <= 1'b1;
                        repeat_start_reg <= next_pc;
                    end
                    `OP_SINGLE_REPEAT_OP: begin
                        // (RQ6) single repeat setup
                        repeat_counter_reg <= src1;
                        status_reg[`ST_RPT_MODE] <= 1'b1;
                        repeat_start_reg <= next_pc;
                        repeat_end_reg <= next_pc;
                    end
                    `OP_INTERLOCK_SIGNAL_OP: begin
                        // (RQ7) raise request and wait
                        interlock_req <= 1'b1;
                        state <= S_WAIT_ACK;
                    end
                    `OP_FLOAT_STORE_INTERLOCKED, `OP_INT_STORE_INTERLOCKED: begin
                        // (RQ8) store and mark interlock end
                        data_addr_bus_a <= dst[23:0];
                        data_data_bus <= src1;
                        data_wr <= 1'b1;
                        interlock_end <= 1'b1;
                    end
                    `OP_TRAP: begin
                        // (RQ12) vector load and interrupt disable
                        if (push_en) begin
                            stack_pointer <= sp_inc;
                            pc <= `TRAP_BASE + {19'h00000, trap_vec};
                            status_reg[`ST_GIE] <= 1'b0;
                        end
                    end
                    `OP_SWI: begin
                        // (RQ14) emulator interrupt sequence start
                        emu_irq <= 1'b1;
                        emu_pending <= 1'b1;
                    end
                    default: begin
                        // (RQ19) 32-bit result and status flags
                        if (alu_write) begin
                            dst <= alu_result;
                        end
                        if (alu_flags) begin
                            status_reg[`ST_NEG] <= alu_result[31];
                            status_reg[`ST_ZERO] <= (alu_result == 32'h0);
                            status_reg[`ST_OVF] <= alu_ovf;
                        end
                        if (alu_carry_upd) begin
                            status_reg[`ST_CARRY] <= alu_carry;
                        end
                    end
                endcase
            end
        end
    end
endmodule // dsp_exec_unit

// [inc/dsp_exec_consts.vh]
// Execution unit constants
`ifndef DSP_EXEC_CONSTS_VH
`define DSP_EXEC_CONSTS_VH

// Register byte offsets
`define OFS_COMMAND 8'h00
`define OFS_DST 8'h04
`define OFS_SRC1 8'h08
`define OFS_SRC2 8'h0C
`define OFS_STATUS 8'h10
`define OFS_STACK_PTR 8'h14
`define OFS_PC 8'h18
`define OFS_RPT_START 8'h1C
`define OFS_RPT_END 8'h20
`define OFS_RPT_COUNT 8'h24
`define OFS_INFO 8'h28
`define OFS_TOS 8'h2C

// Command register fields
`define CMD_OP_MSB 4
`define CMD_COND_BIT 8
`define CMD_VEC_LSB 16
`define CMD_VEC_MSB 20

// Status register bit positions
`define ST_CARRY 0
`define ST_OVF 1
`define ST_ZERO 2
`define ST_NEG 3
`define ST_RPT_MODE 8
`define ST_GIE 13

// Info register bit positions
`define INFO_BUSY 0
`define INFO_EMU 1
`define INFO_LOCK 2

// Reset values
`define RST_STATUS 32'h0
`define RST_SP 32'h0
`define RST_PC 24'h0

// Trap vectors
`define TRAP_VEC_LAST 5'h1B
`define TRAP_BASE 24'h000020

// Operation codes
`define OP_NOP 5'h00
`define OP_RETI 5'h01
`define OP_RETS 5'h02
`define OP_ROL 5'h03
`define OP_ROLC 5'h04
`define OP_ROR 5'h05
`define OP_RORC 5'h06
`define OP_BLOCK_REPEAT_OP 5'h07
`define OP_SINGLE_REPEAT_OP 5'h08
`define OP_INTERLOCK_SIGNAL_OP 5'h09
`define OP_FLOAT_STORE_INTERLOCKED 5'h0A
`define OP_INT_STORE_INTERLOCKED 5'h0B
`define OP_SUBB 5'h0C
`define OP_SUBB3 5'h0D
`define OP_CONDITIONAL_SUBTRACT_OP 5'h0E
`define OP_SUBRB 5'h0F
`define OP_SUBRI 5'h10
`define OP_TRAP 5'h11
`define OP_BIT_TEST_OP 5'h12
`define OP_TSTB3 5'h13
`define OP_SWI 5'h14

`endif

// [verilog/int_alu.v]
// Integer rotate, subtract and bit-test datapath
`timescale 1ns/1ps
`include "dsp_exec_consts.vh"
module int_alu (
    input wire [4:0] op,
    input wire [31:0] dst,
    input wire [31:0] src1,
    input wire [31:0] src2,
    input wire carry_in,
    output reg [31:0] result,
    output reg carry_out,
    output reg overflow,
    output reg write_dst,
    output reg flags_upd,
    output reg carry_upd
);
    reg [31:0] sub_a;
    reg [31:0] sub_b;
    reg sub_c;
    reg [32:0] diff;

    always @* begin
        sub_a = dst;
        sub_b = src1;
        sub_c = 1'b0;
        case (op)
            `OP_SUBB3: begin
                sub_a = src1;
                sub_b = src2;
                sub_c = carry_in;
            end
            `OP_SUBB: sub_c = carry_in;
            `OP_SUBRB: begin
                sub_a = src1;
                sub_b = dst;
                sub_c = carry_in;
            end
            `OP_SUBRI: begin
                sub_a = src1;
                sub_b = dst;
            end
            default: sub_c = 1'b0;
        endcase
        // Bit 32 is the borrow out
        diff = {1'b0, sub_a} - {1'b0, sub_b} - {32'h0, sub_c};
        result = dst;
        carry_out = carry_in;
        overflow = 1'b0;
        write_dst = 1'b1;
        flags_upd = 1'b1;
        carry_upd = 1'b1;
        case (op)
            // (RQ3) one-bit ring rotate
            `OP_ROL: begin
                result = {dst[30:0], dst[31]};
                carry_out = dst[31];
            end
            `OP_ROR: begin
                result = {dst[0], dst[31:1]};
                carry_out = dst[0];
            end
            // (RQ4) rotate through carry
            `OP_ROLC: begin
                result = {dst[30:0], carry_in};
                carry_out = dst[31];
            end
            `OP_RORC: begin
                result = {carry_in, dst[31:1]};
                carry_out = dst[0];
            end
            // (RQ9) (RQ11) borrow and reverse subtracts
            `OP_SUBB, `OP_SUBB3, `OP_SUBRB, `OP_SUBRI: begin
                result = diff[31:0];
                carry_out = diff[32];
                overflow = (sub_a[31] ^ sub_b[31]) & (sub_a[31] ^ diff[31]);
            end
            // (RQ10) conditional subtract step
            `OP_CONDITIONAL_SUBTRACT_OP: begin
                flags_upd = 1'b0;
                carry_upd = 1'b0;
                if (!diff[32]) begin
                    result = {diff[30:0], 1'b1};
                end else begin
                    result = {dst[30:0], 1'b0};
                end
            end
            // (RQ13) test only, no write-back
            `OP_BIT_TEST_OP, `OP_TSTB3: begin
                write_dst = 1'b0;
                carry_upd = 1'b0;
                result = (op == `OP_BIT_TEST_OP) ? (dst & src1) : (src1 & src2);
            end
            default: begin
                write_dst = 1'b0;
                flags_upd = 1'b0;
                carry_upd = 1'b0;
            end
        endcase
    end
endmodule // int_alu

// [verilog/stack_ram.v]
// Stack memory, clocked write, combinational read
`timescale 1ns/1ps
module stack_ram #(
    parameter ADDR_W = 4
) (
    input wire pclk,
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [31:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr,
    output wire [31:0] rd_data
);
    reg [31:0] mem [0:(1<<ADDR_W)-1];

    // Contents are undefined until pushed; no reset keeps it a plain RAM
    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule // stack_ram

// [sim/mem_periph_model.sv]
// Behavioural memories, DMA source and interlock partner
`timescale 1ns/1ps
module mem_periph_model (
    input wire pclk,
    input wire presetn,
    input wire [23:0] program_addr_bus,
    input wire [23:0] data_addr_bus_a,
    input wire interlock_req,
    input wire [3:0] ack_delay,
    output logic [31:0] program_data_bus,
    output logic [31:0] data_rd_a,
    output logic [31:0] data_rd_b,
    output logic [23:0] dma_addr_in,
    output logic [31:0] dma_data_in,
    output logic interlock_ack
);
    logic [31:0] tick;
    logic [3:0] wait_cnt;
    // Changes every cycle so stale bus values show
    assign program_data_bus = {8'h5A, program_addr_bus} ^ tick;
    assign data_rd_a = {data_addr_bus_a, 8'h3C} ^ tick;
    assign data_rd_b = ~tick;
    assign dma_addr_in = tick[23:0];
    assign dma_data_in = {tick[15:0], ~tick[15:0]};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 32'h0;
            wait_cnt <= 4'h0;
            interlock_ack <= 1'b0;
        end else begin
            tick <= tick * 32'h0019660D + 32'h3C6EF35F;
            if (!interlock_req) begin
                wait_cnt <= 4'h0;
                interlock_ack <= 1'b0;
            end else if (wait_cnt < ack_delay) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                interlock_ack <= 1'b1;
            end
        end
    end
endmodule // mem_periph_model

// [sim/dsp_exec_monitor.sv]
// Port checker for the execution unit
`timescale 1ns/1ps
module dsp_exec_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] program_data_bus,
    input wire [31:0] instruction_reg,
    input wire [31:0] data_rd_b,
    input wire [31:0] cpu_operand_bus_b,
    input wire [23:0] dma_addr_in,
    input wire [23:0] dma_addr_bus,
    input wire data_wr,
    input wire interlock_req,
    input wire interlock_ack,
    input wire interlock_end,
    input wire emu_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Busy drops commands
    wire cmd_go = psel && penable && pwrite && paddr == 32'h0 && !interlock_req;
    chk_err_ready:
        assert property (pslverr |-> pready) else $error("error outside access");
    chk_ir_fetch:
        assert property ($past(presetn) |-> instruction_reg == $past(program_data_bus))
        else $error("fetch missed");
    chk_cpu_operand:
        assert property ($past(presetn) |-> cpu_operand_bus_b == $past(data_rd_b))
        else $error("operand bus stale");
    chk_dma_path:
        assert property ($past(presetn) |-> dma_addr_bus == $past(dma_addr_in))
        else $error("dma bus stale");
    chk_lock_start:
        assert property (cmd_go && pwdata[4:0] == 5'h09 |=> interlock_req)
        else $error("no interlock request");
    chk_lock_hold:
        assert property (interlock_req && !interlock_ack |=> interlock_req)
        else $error("request dropped early");
    chk_lock_release:
        assert property ((interlock_req && interlock_ack) [*3] |=> !interlock_req)
        else $error("request held too long");
    chk_store_pulse:
        assert property (cmd_go && pwdata[4:1] == 4'h5 |=> data_wr && interlock_end
            ##1 !data_wr && !interlock_end) else $error("store pulse wrong");
    chk_end_pair:
        assert property (interlock_end |-> data_wr) else $error("end without store");
    chk_swi_pulse:
        assert property (cmd_go && pwdata[4:0] == 5'h14 |=> emu_irq ##1 !emu_irq)
        else $error("emulator pulse wrong");
endmodule // dsp_exec_monitor

bind dsp_exec_unit dsp_exec_monitor u_dsp_exec_monitor (.*);

// [sim/tb_dsp_control_and_integer_ops.sv]
// Bench for the execution unit
`timescale 1ns/1ps
`include "dsp_exec_consts.vh"
module tb_dsp_control_and_integer_ops;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic data_wr, interlock_req, interlock_ack, interlock_end, emu_irq, c;
    logic [31:0] paddr, pwdata, prdata, program_data_bus, instruction_reg, data_rd_a;
    logic [31:0] data_rd_b, data_data_bus, cpu_operand_bus_a, cpu_operand_bus_b;
    logic [31:0] reg_operand_bus_a, reg_operand_bus_b, dma_data_in, dma_data_bus;
    logic [23:0] program_addr_bus, data_addr_bus_a, data_addr_bus_b, dma_addr_in, dma_addr_bus;
    logic [3:0] ack_delay;
    logic [55:0] rd_q[$];
    logic [55:0] st_q[$];
    logic [31:0] d, s1, s2;
    logic [63:0] e;
    logic [4:0] ops [0:10];
    integer err_total, tests_run, seed, i;

    dsp_exec_unit u_dsp_exec_unit (.*);
    mem_periph_model u_mem_periph_model (.*);

    always #50 pclk = ~pclk;

    task summarize;
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task cmp(input logic [55:0] g, input logic [55:0] x);
        tests_run++;
        if (g !== x) begin
            err_total++;
            $display("Error at %0t: got %h exp %h", $time, g, x);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x);
        rd_q.push_back({24'h0, x});
        apb(1'b0, a, 32'h0);
    endtask

    task cmd(input logic [4:0] op, input logic cnd, input logic [4:0] v);
        wr(`OFS_COMMAND, {11'h0, v, 7'h00, cnd, 3'h0, op});
    endtask

    // Status flags above destination
    function automatic logic [63:0] model(input logic [4:0] op, input logic [31:0] d,
        input logic [31:0] s1, input logic [31:0] s2, input logic c);
        logic [31:0] a, b, r, f;
        logic [32:0] t;
        logic co, v, ci;
        v = 1'b0;
        co = c;
        case (op)
            `OP_SUBB: {a, b, ci} = {d, s1, c};
            `OP_SUBB3: {a, b, ci} = {s1, s2, c};
            `OP_SUBRB: {a, b, ci} = {s1, d, c};
            default: {a, b, ci} = {s1, d, 1'b0};
        endcase
        t = {1'b0, a} - {1'b0, b} - {32'h0, ci};
        r = t[31:0];
        case (op)
            `OP_ROL: {co, r} = {d, d[31]};
            `OP_ROLC: {co, r} = {d, c};
            `OP_ROR: {r, co} = {d[0], d};
            `OP_RORC: {r, co} = {c, d};
            5'h0E: begin
                t = {1'b0, d} - {1'b0, s1};
                r = t[32] ? {d[30:0], 1'b0} : {t[30:0], 1'b1};
            end
            5'h12, `OP_TSTB3: r = d;
            default: begin
                co = t[32];
                v = (a[31] ^ b[31]) & (r[31] ^ a[31]);
            end
        endcase
        f = op == 5'h12 ? d & s1 : op == `OP_TSTB3 ? s1 & s2 : r;
        model = {28'h0, f[31], f == 32'h0, v, co, r};
        if (op == 5'h0E)
            model[35:32] = {3'h0, c};
    endfunction

    always @(negedge pclk) begin
        if (psel && penable && !pwrite)
            cmp({23'h0, pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 56'hX);
        if (data_wr === 1'b1)
            cmp({data_addr_bus_a, data_data_bus}, st_q.size() ? st_q.pop_front() : 56'hX);
    end

    initial begin
        repeat (6000) @(posedge pclk);
        err_total++;
        summarize;
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        ack_delay = 4'h9;
        err_total = 0;
        tests_run = 0;
        seed = 39;
        ops = '{`OP_ROL, `OP_ROLC, `OP_ROR, `OP_RORC, `OP_SUBB, `OP_SUBB3, 5'h0E,
            `OP_SUBRB, `OP_SUBRI, 5'h12, `OP_TSTB3};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_PC, 32'h0);
        rd(`OFS_COMMAND, 32'h0);
        rd_q.push_back({24'h1, 32'h0});
        apb(1'b0, 8'h30, 32'h0);
        for (i = 0; i < 44; i = i + 1) begin
            d = $random(seed);
            s1 = (i % 4 == 3) ? d : $random(seed);
            s2 = $random(seed);
            c = s2[5];
            e = model(ops[i % 11], d, s1, s2, c);
            wr(`OFS_DST, d);
            wr(`OFS_SRC1, s1);
            wr(`OFS_SRC2, s2);
            wr(`OFS_STATUS, {31'h0, c});
            cmd(ops[i % 11], 1'b1, 5'h00);
            rd(`OFS_DST, e[31:0]);
            rd(`OFS_STATUS, e[63:32]);
        end
        wr(`OFS_STACK_PTR, 32'h5);
        wr(`OFS_PC, 32'h100);
        wr(`OFS_STATUS, 32'h2000);
        cmd(5'h11, 1'b1, 5'h1B);
        rd(`OFS_PC, 32'h3B);
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_TOS, 32'h101);
        cmd(5'h11, 1'b1, 5'h1C);
        cmd(5'h11, 1'b0, 5'h03);
        cmd(5'h01, 1'b0, 5'h00);
        cmd(5'h02, 1'b0, 5'h00);
        rd(`OFS_PC, 32'h3B);
        rd(`OFS_STACK_PTR, 32'h6);
        cmd(5'h01, 1'b1, 5'h00);
        rd(`OFS_PC, 32'h101);
        rd(`OFS_STACK_PTR, 32'h5);
        rd(`OFS_STATUS, 32'h2000);
        cmd(5'h11, 1'b1, 5'h00);
        rd(`OFS_PC, 32'h20);
        cmd(5'h02, 1'b1, 5'h00);
        rd(`OFS_PC, 32'h102);
        rd(`OFS_STACK_PTR, 32'h5);
        wr(`OFS_PC, 32'h200);
        wr(`OFS_SRC1, 32'h345);
        wr(`OFS_STATUS, 32'h0);
        cmd(5'h07, 1'b1, 5'h00);
        rd(`OFS_RPT_END, 32'h345);
        rd(`OFS_RPT_START, 32'h201);
        rd(`OFS_STATUS, 32'h100);
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_SRC1, 32'h9);
        cmd(5'h08, 1'b1, 5'h00);
        rd(`OFS_RPT_COUNT, 32'h9);
        rd(`OFS_RPT_END, 32'h201);
        rd(`OFS_STATUS, 32'h100);
        for (i = 0; i < 2; i = i + 1) begin
            ack_delay <= i ? 4'h0 : 4'h9;
            cmd(5'h09, 1'b1, 5'h00);
            if (i == 0)
                rd(`OFS_INFO, 32'h5);
            @(negedge pclk);
            while (interlock_req !== 1'b0) @(negedge pclk);
            @(posedge pclk);
            rd(`OFS_INFO, 32'h0);
        end
        for (i = 0; i < 2; i = i + 1) begin
            d = $random(seed);
            s1 = $random(seed);
            wr(`OFS_DST, d);
            wr(`OFS_SRC1, s1);
            st_q.push_back({d[23:0], s1});
            cmd(i ? 5'h0B : 5'h0A, 1'b1, 5'h00);
        end
        cmd(5'h14, 1'b1, 5'h00);
        rd(`OFS_INFO, 32'h2);
        wr(`OFS_INFO, 32'h2);
        rd(`OFS_INFO, 32'h0);
        repeat (3) @(posedge pclk);
        summarize;
    end
endmodule // tb_dsp_control_and_integer_ops
